//--- mtp_pkg.sv
/*
  constants, decode kinds and request carriers for the machine timer
  and performance counter block; assumes a single 100 MHz hart clock
*/
`default_nettype none

package mtp_pkg;

  // widths and counts
  localparam int CNT_W = 64;
  localparam int HALF_W = 32;
  localparam int NUM_CNT = 32;
  localparam int FIRST_EVT = 3;
  localparam int SEL_W = 5;
  localparam int EVT_SRC = 16;
  localparam int IDX_W = 5;

  // privilege encodings
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;

  // memory-mapped word offsets (byte addresses)
  localparam logic [3:0] MMIO_TIME_LO = 4'h0;
  localparam logic [3:0] MMIO_TIME_HI = 4'h4;
  localparam logic [3:0] MMIO_CMP_LO = 4'h8;
  localparam logic [3:0] MMIO_CMP_HI = 4'hc;

  // control-register addresses
  localparam logic [11:0] CSR_MCNT_BASE = 12'h700;
  localparam logic [11:0] CSR_UCNT_BASE = 12'h800;
  localparam logic [11:0] CSR_CNT_MASK = 12'hf60;
  localparam logic [11:0] CSR_SEL_BASE = 12'h600;
  localparam logic [11:0] CSR_SEL_MASK = 12'hfe0;
  localparam logic [11:0] CSR_MGATE = 12'h640;
  localparam logic [11:0] CSR_SGATE = 12'h641;
  localparam logic [11:0] CSR_IEN = 12'h642;
  localparam logic [11:0] CSR_IPEND = 12'h643;
  localparam int CSR_HIGH_BIT = 7;

  // field positions and writable masks
  localparam int GATE_CY = 0;
  localparam int GATE_TM = 1;
  localparam int GATE_IR = 2;
  localparam int MTIMER_BIT = 7;
  localparam logic [31:0] FREEZE_WARL = 32'hffff_fffd;
  localparam logic [31:0] IEN_WARL = 32'h0000_0080;
  localparam logic [4:0] IDX_TIME = 5'h01;

  // reset values
  localparam logic [63:0] CNT_RST = 64'h0;
  localparam logic [31:0] REG_RST = 32'h0;

  // one-hot control-register decode classes
  typedef enum logic [8:0] {
    K_NONE = 9'h001,
    K_MCNT = 9'h002,
    K_UCNT = 9'h004,
    K_SEL = 9'h008,
    K_FREEZE = 9'h010,
    K_MGATE = 9'h020,
    K_SGATE = 9'h040,
    K_IEN = 9'h080,
    K_IPEND = 9'h100
  } mtp_kind_e;

  typedef struct packed {
    mtp_kind_e kind;
    logic [4:0] idx;
    logic high;
  } mtp_dec_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [1:0] priv;
  } mtp_csr_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] addr;
    logic [31:0] wdata;
  } mtp_mmio_req_s;

endpackage : mtp_pkg

`default_nettype wire

//--- mtp_timebase_src.sv
/*
  constant-rate timebase model standing in for the real-time clock
  assumes ref_clk runs free; level held four cycles per toggle
*/
`timescale 1ns/10ps
`default_nettype none
module mtp_timebase_src (
  // clock and control
  input wire logic ref_clk,
  input wire logic run,
  // timebase level and toggle count
  output logic tick,
  output int steps
);
  int cnt = 0;
  initial tick = 1'b0;
  initial steps = 0;
  always @(posedge ref_clk)
  begin
    if (run)
      cnt <= cnt + 1;
    if (run && cnt % 4 == 3)
    begin
      tick <= ~tick;
      steps <= steps + 1;
    end
  end
endmodule : mtp_timebase_src
`default_nettype wire

//--- mtp_timer_counters.sv
/*
  machine timer and performance counters: memory-mapped wall clock and
  compare, cycle / retired / event counters, access gates, freeze mask;
  assumes requests and retire/event strobes come on ref_clk and that the
  timebase tick is an asynchronous level toggling slower than ref_clk/4
*/
`timescale 1ns/10ps
`default_nettype none

// Contract
// [R1] 64-bit wall clock counter, read and written via memory-mapped words.
// [R2] wall clock advances from constant-rate timebase, not core clock.
// [R3] timer pending when wall clock >= compare, unsigned 64-bit.
// [R4] pending holds until compare is written, then re-evaluated.
// [R5] timer taken only with global enable and timer enable bit.
// [R6] counter or compare writes reach pending bit within a cycle.
// [R7] a 32-bit write to compare changes only the addressed half.
// [R8] software writes all ones low, then high, then low.
// [R9] 64-bit cycle counter and retired-instruction counter.
// [R10] counters writable; write lands after the instruction completes.
// [R11] 29 event counters 3..31 with selectors; selector 0 is no event.
// [R12] any event counter may be hard-wired; all are implemented here.
// [R13] low-half addresses read bits 31-0, high-half bits 63-32.
// [R14] 32-bit gates: bit0 cycle, bit1 time, bit2 retired, 3..31 events.
// [R15] gate accesses never touch counters; counting continues regardless.
// [R16] clear machine gate bit makes lower-mode shadow read illegal.
// [R17] user reads also need the supervisor gate bit set.
// [R18] gates are WARL and present for user and supervisor modes.
// [R19] unprivileged registers are read-only shadows; time shadows wall clock.
// [R20] 32-bit freeze mask; set bit stops that counter incrementing.
// [R21] freeze mask never affects access checks.
// [R22] freeze bit 1 always reads zero; wall clock never freezes.
// [R23] one cycle counter and one cycle-freeze bit for the core.
// [R24] timer pending is bit 7 read-only; timer enable is bit 7.
// [R25] wall clock steps once per synchronised timebase tick.
module mtp_timer_counters
  import mtp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // timebase tick, asynchronous
  input wire logic timebaseTick,
  // memory-mapped port
  input wire mtp_mmio_req_s mmioReq,
  output logic [31:0] mmioRdata,
  output logic mmioDone,
  // control-register port
  input wire mtp_csr_req_s csrReq,
  output logic [31:0] csrRdata,
  output logic csrIllegal,
  output logic csrDone,
  // core events
  input wire logic instRetire,
  input wire logic [EVT_SRC-1:0] eventBus,
  // interrupt status
  input wire logic globalIrqEnable,
  output logic timerPending,
  output logic timerIrqTake
);

  // decode a control-register address into class, index and half
  function automatic mtp_dec_s csrDecode(input logic [11:0] addr);
    mtp_dec_s dec;
    dec.idx = addr[IDX_W-1:0];
    dec.high = addr[CSR_HIGH_BIT];
    dec.kind = K_NONE;
    if ((addr & CSR_CNT_MASK) == CSR_MCNT_BASE)
    begin
      // machine time lives only on the memory-mapped port
      if (dec.idx != IDX_TIME)
        dec.kind = K_MCNT;
    end
    else if ((addr & CSR_CNT_MASK) == CSR_UCNT_BASE)
      dec.kind = K_UCNT;
    else if ((addr & CSR_SEL_MASK) == CSR_SEL_BASE)
    begin
      if (dec.idx == 5'h00)
        dec.kind = K_FREEZE;
      else if (dec.idx >= 5'(FIRST_EVT))
        dec.kind = K_SEL;
    end
    else if (addr == CSR_MGATE)
      dec.kind = K_MGATE;
    else if (addr == CSR_SGATE)
      dec.kind = K_SGATE;
    else if (addr == CSR_IEN)
      dec.kind = K_IEN;
    else if (addr == CSR_IPEND)
      dec.kind = K_IPEND;
    return dec;
  endfunction : csrDecode

  // WARL selector: anything beyond the event sources reads back as 0
  function automatic logic [SEL_W-1:0] selLegal(input logic [31:0] value);
    logic [SEL_W-1:0] res;
    res = '0;
    if (value <= 32'(EVT_SRC))
      res = value[SEL_W-1:0];
    return res;
  endfunction : selLegal

  // state
  logic tickSync1;
  logic tickSync2;
  logic tickSync3;
  logic [CNT_W-1:0] wallCount;
  logic [CNT_W-1:0] wallCompare;
  logic recompare;
  logic [31:0] machineGate;
  logic [31:0] superGate;
  logic [31:0] freezeMask;
  logic [31:0] intEnable;
  logic [CNT_W-1:0] cnt [0:NUM_CNT-1];
  logic [SEL_W-1:0] evtSel [FIRST_EVT:NUM_CNT-1];
  logic [NUM_CNT-1:0] cntInc;

  // request decode
  mtp_dec_s dec;
  logic privM;
  logic privSOrM;
  logic shadowOk;
  logic csrLegal;
  logic csrWr;
  logic mmioWr;
  logic tickEdge;
  logic timeGe;
  logic [CNT_W-1:0] selCnt;
  logic [SEL_W-1:0] selRead;
  logic [31:0] pendWord;
  logic [31:0] next_csrRdata;
  logic [31:0] next_mmioRdata;
  logic [CNT_W-1:0] next_wallCount;
  logic [CNT_W-1:0] next_wallCompare;

  // timebase crossing; the second and third stages feed the edge detector
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickSync1 <= 1'b0;
      tickSync2 <= 1'b0;
      tickSync3 <= 1'b0;
    end
    else
    begin
      tickSync1 <= timebaseTick;
      tickSync2 <= tickSync1;
      tickSync3 <= tickSync2;
    end
  end

  // [R25] one step per tick
  // [R2] either edge of the slow timebase counts, core clock rate is moot
  assign tickEdge = tickSync2 ^ tickSync3;

  // memory-mapped write decode
  assign mmioWr = mmioReq.valid & mmioReq.write;

  // [R1] wall clock half writes, otherwise count
  always_comb
  begin
    next_wallCount = wallCount + CNT_W'(tickEdge);
    if (mmioWr && mmioReq.addr == MMIO_TIME_LO)
      next_wallCount = {wallCount[CNT_W-1:HALF_W], mmioReq.wdata};
    else if (mmioWr && mmioReq.addr == MMIO_TIME_HI)
      next_wallCount = {mmioReq.wdata, wallCount[HALF_W-1:0]};
  end

  // [R7] only the addressed compare half changes
  always_comb
  begin
    next_wallCompare = wallCompare;
    if (mmioWr && mmioReq.addr == MMIO_CMP_LO)
      next_wallCompare = {wallCompare[CNT_W-1:HALF_W], mmioReq.wdata};
    else if (mmioWr && mmioReq.addr == MMIO_CMP_HI)
      next_wallCompare = {mmioReq.wdata, wallCompare[HALF_W-1:0]};
  end

  // [R3] unsigned compare on full 64 bits
  assign timeGe = wallCount >= wallCompare;

  // wall clock, compare and timer pending registers
  // [R4] a write arms re-evaluation; otherwise pending is sticky
  // [R6] the re-evaluation happens one cycle after the write lands
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wallCount <= CNT_RST;
      wallCompare <= CNT_RST;
      recompare <= 1'b0;
      timerPending <= 1'b0;
    end
    else
    begin
      wallCount <= next_wallCount;
      wallCompare <= next_wallCompare;
      recompare <= mmioWr;
      if (recompare)
        timerPending <= timeGe;
      else
        timerPending <= timerPending | timeGe;
    end
  end

  // [R5] take only with global enable and timer enable bit
  assign timerIrqTake = timerPending & intEnable[MTIMER_BIT] &
                        globalIrqEnable;

  // memory-mapped read mux; all four words are mapped
  always_comb
  begin
    unique case (mmioReq.addr)
      MMIO_TIME_LO: next_mmioRdata = wallCount[HALF_W-1:0];
      MMIO_TIME_HI: next_mmioRdata = wallCount[CNT_W-1:HALF_W];
      MMIO_CMP_LO: next_mmioRdata = wallCompare[HALF_W-1:0];
      MMIO_CMP_HI: next_mmioRdata = wallCompare[CNT_W-1:HALF_W];
      default: next_mmioRdata = REG_RST;
    endcase
  end

  // memory-mapped answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mmioRdata <= REG_RST;
      mmioDone <= 1'b0;
    end
    else
    begin
      mmioDone <= mmioReq.valid;
      if (mmioReq.valid && !mmioReq.write)
        mmioRdata <= next_mmioRdata;
    end
  end

  // control-register decode and privilege checks
  assign dec = csrDecode(csrReq.addr);
  assign privM = csrReq.priv == PRIV_M;
  assign privSOrM = privM | (csrReq.priv == PRIV_S);

  // [R16] supervisor needs the machine gate bit
  // [R17] user needs machine and supervisor gate bits
  // [R21] the freeze mask plays no part here
  assign shadowOk = privM |
    ((csrReq.priv == PRIV_S) & machineGate[dec.idx]) |
    ((csrReq.priv == PRIV_U) & machineGate[dec.idx] & superGate[dec.idx]);

  // [R19] shadows are read-only, so writes to them are illegal
  always_comb
  begin
    unique case (dec.kind)
      K_UCNT: csrLegal = shadowOk & ~csrReq.write;
      K_SGATE: csrLegal = privSOrM;
      K_MCNT, K_SEL, K_FREEZE, K_MGATE, K_IEN, K_IPEND: csrLegal = privM;
      default: csrLegal = 1'b0;
    endcase
  end

  assign csrWr = csrReq.valid & csrReq.write & csrLegal;
  // [R10] counter writes land at the taking edge, replacing that step
  // [R11] per-counter increment sources; selector 0 matches nothing
  // [R12] every event counter is implemented, none hard-wired
  // [R20] a set freeze bit stops the step, never the write
  // [R23] the single cycle counter shares one freeze bit
  generate
    for (genvar i = 0; i < NUM_CNT; i++)
    begin : g_cnt
      if (i == GATE_TM)
      begin : g_time
        // [R19] the time shadow reads the wall clock
        assign cnt[i] = wallCount;
        // [R22] the wall clock has no freeze path
        assign cntInc[i] = 1'b0;
      end
      else
      begin : g_real
        logic hit;
        logic wrLo;
        logic wrHi;
        if (i == GATE_CY)
        begin : g_cy
          // [R9] cycles counted every core clock
          assign hit = 1'b1;
        end
        else if (i == GATE_IR)
        begin : g_ir
          // [R9] retired instructions
          assign hit = instRetire;
        end
        else
        begin : g_evt
          assign hit = (evtSel[i] != '0) &&
                       eventBus[4'(evtSel[i] - 5'h01)];
        end
        assign cntInc[i] = hit & ~freezeMask[i];
        assign wrLo = csrWr && dec.kind == K_MCNT &&
                      dec.idx == 5'(i) && !dec.high;
        assign wrHi = csrWr && dec.kind == K_MCNT &&
                      dec.idx == 5'(i) && dec.high;
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
          if (!rst_b)
            cnt[i] <= CNT_RST;
          else if (wrLo)
            cnt[i] <= {cnt[i][CNT_W-1:HALF_W], csrReq.wdata};
          else if (wrHi)
            cnt[i] <= {csrReq.wdata, cnt[i][HALF_W-1:0]};
          else if (cntInc[i])
            cnt[i] <= cnt[i] + CNT_W'(1);
        end
      end
    end
    // [R11] WARL event selectors 3..31
    for (genvar j = FIRST_EVT; j < NUM_CNT; j++)
    begin : g_sel
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          evtSel[j] <= '0;
        else if (csrWr && dec.kind == K_SEL && dec.idx == 5'(j))
          evtSel[j] <= selLegal(csrReq.wdata);
      end
    end
  endgenerate

  // [R14] [R18] WARL gates, all 32 bits writable
  // [R15] gate writes touch nothing but the gate itself
  // [R22] freeze bit 1 is not stored
  // [R24] only the timer enable bit is held in the enable word
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      machineGate <= REG_RST;
      superGate <= REG_RST;
      freezeMask <= REG_RST;
      intEnable <= REG_RST;
    end
    else
    begin
      if (csrWr && dec.kind == K_MGATE)
        machineGate <= csrReq.wdata;
      if (csrWr && dec.kind == K_SGATE)
        superGate <= csrReq.wdata;
      if (csrWr && dec.kind == K_FREEZE)
        freezeMask <= csrReq.wdata & FREEZE_WARL;
      if (csrWr && dec.kind == K_IEN)
        intEnable <= csrReq.wdata & IEN_WARL;
    end
  end

  // read-side selection
  assign selCnt = cnt[dec.idx];
  assign selRead = (dec.idx >= 5'(FIRST_EVT)) ? evtSel[dec.idx] : '0;
  // [R24] pending word shows only the read-only timer bit
  assign pendWord = REG_RST | (32'(timerPending) << MTIMER_BIT);

  // [R13] the high-address bit picks bits 63-32
  always_comb
  begin
    unique case (dec.kind)
      K_MCNT, K_UCNT: next_csrRdata = dec.high ?
        selCnt[CNT_W-1:HALF_W] : selCnt[HALF_W-1:0];
      K_SEL: next_csrRdata = 32'(selRead);
      K_FREEZE: next_csrRdata = freezeMask;
      K_MGATE: next_csrRdata = machineGate;
      K_SGATE: next_csrRdata = superGate;
      K_IEN: next_csrRdata = intEnable;
      K_IPEND: next_csrRdata = pendWord;
      default: next_csrRdata = REG_RST;
    endcase
  end

  // control-register answer, one cycle after the request
  // refused accesses return zero so nothing leaks through the trap
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      csrRdata <= REG_RST;
      csrIllegal <= 1'b0;
      csrDone <= 1'b0;
    end
    else
    begin
      csrDone <= csrReq.valid;
      csrIllegal <= csrReq.valid & ~csrLegal;
      if (csrReq.valid)
        csrRdata <= csrLegal ? next_csrRdata : REG_RST;
    end
  end

endmodule : mtp_timer_counters

`default_nettype wire

//--- mtp_timer_counters_asserts.sv
/*
  port checker for the timer and counter block
  assumes one ref_clk domain; bound onto mtp_timer_counters below
*/
`timescale 1ns/10ps
`default_nettype none
module mtp_timer_counters_asserts
  import mtp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic timebaseTick,
  // memory-mapped port
  input wire mtp_mmio_req_s mmioReq,
  input wire logic [31:0] mmioRdata,
  input wire logic mmioDone,
  // control-register port
  input wire mtp_csr_req_s csrReq,
  input wire logic [31:0] csrRdata,
  input wire logic csrIllegal,
  input wire logic csrDone,
  // events and interrupt
  input wire logic instRetire,
  input wire logic [EVT_SRC-1:0] eventBus,
  input wire logic globalIrqEnable,
  input wire logic timerPending,
  input wire logic timerIrqTake
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // request decode shared by the properties
  wire logic mmWr = mmioReq.valid & mmioReq.write;
  wire logic csrRd = csrReq.valid & ~csrReq.write;
  wire logic mach = csrReq.priv == PRIV_M;
  wire logic [3:0] page = csrReq.addr[11:8];
  sequence s_mm_req;
    mmioReq.valid;
  endsequence
  sequence s_csr_req;
    csrReq.valid;
  endsequence
  a_mmio_done_lat: assert property (s_mm_req |=> mmioDone)
    else $error("mmio done missing");
  a_mmio_done_only: assert property (!mmioReq.valid |=> !mmioDone)
    else $error("mmio done without request");
  a_csr_done_lat: assert property (s_csr_req |=> csrDone)
    else $error("csr done missing");
  a_illegal_zero_data: assert property (
    csrIllegal |-> csrDone && csrRdata == 32'h0)
    else $error("refused access returned data");
  a_shadow_write_refused: assert property (
    csrReq.valid && csrReq.write && page == 4'h8 |=> csrIllegal)
    else $error("shadow write accepted");
  a_machine_priv_only: assert property (
    csrReq.valid && page == 4'h7 && !mach |=> csrIllegal)
    else $error("machine counter open to lower mode");
  // pending may only fall one or two cycles after a memory-mapped write
  a_pending_sticky: assert property (
    timerPending && !mmWr && !$past(mmWr) |=> timerPending)
    else $error("timer pending fell without a write");
  a_take_needs_both: assert property (
    timerIrqTake |-> timerPending && globalIrqEnable)
    else $error("timer taken while not enabled");
  a_pend_bit_read: assert property (
    csrRd && csrReq.addr == CSR_IPEND && mach
    |=> !csrIllegal && csrRdata[7] == $past(timerPending))
    else $error("pending bit read mismatch");
  a_freeze_bit1_zero: assert property (
    csrRd && csrReq.addr == CSR_SEL_BASE && mach |=> !csrRdata[1])
    else $error("freeze bit 1 not zero");
endmodule : mtp_timer_counters_asserts
bind mtp_timer_counters mtp_timer_counters_asserts u_chk (.ref_clk,
  .rst_b, .timebaseTick, .mmioReq, .mmioRdata, .mmioDone, .csrReq,
  .csrRdata, .csrIllegal, .csrDone, .instRetire, .eventBus,
  .globalIrqEnable, .timerPending, .timerIrqTake);
`default_nettype wire

//--- test_machine_timer_and_perf_counters.sv
/*
  self-checking bench for the timer and counter block
  assumes the checker is bound and the timebase model drives the tick
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %h got %h", nm, e, g); end end
module test_machine_timer_and_perf_counters;
  import mtp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic tbRun = 1'b0;
  logic timebaseTick, mmioDone, csrIllegal, csrDone;
  logic timerPending, timerIrqTake, ill;
  logic instRetire = 1'b0;
  logic globalIrqEnable = 1'b0;
  logic [15:0] eventBus = '0;
  logic [31:0] mmioRdata, csrRdata, rd, w, v;
  mtp_mmio_req_s mmioReq = '0;
  mtp_csr_req_s csrReq = '0;
  int seed = 50502;
  int miscompares = 0;
  int n_tests = 0;
  int steps, base, n, k;
  mtp_timer_counters DUT (.ref_clk, .rst_b, .timebaseTick, .mmioReq,
    .mmioRdata, .mmioDone, .csrReq, .csrRdata, .csrIllegal, .csrDone,
    .instRetire, .eventBus, .globalIrqEnable, .timerPending,
    .timerIrqTake);
  mtp_timebase_src u_tb (.ref_clk, .run(tbRun), .tick(timebaseTick),
    .steps);
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  task automatic mm(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    mmioReq <= '{1'b1, wr, a, d};
    @(posedge ref_clk);
    mmioReq.valid <= 1'b0;
    #1;
    `CHK("mmioDone", 1'b1, mmioDone)
    rd = mmioRdata;
  endtask : mm
  task automatic cs(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [1:0] p);
    @(posedge ref_clk);
    csrReq <= '{1'b1, wr, a, d, p};
    @(posedge ref_clk);
    csrReq.valid <= 1'b0;
    #1;
    `CHK("csrDone", 1'b1, csrDone)
    rd = csrRdata;
    ill = csrIllegal;
  endtask : cs
  // lower modes need every gate on the path down from machine mode
  function automatic logic expIll(logic [1:0] p, logic m, logic s);
    return (p == PRIV_S) ? !m : !(m && s);
  endfunction : expIll
  task automatic end_of_test;
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    cs(1, CSR_SEL_BASE, 32'hffff_ffff, PRIV_M);
    cs(0, CSR_SEL_BASE, 0, PRIV_M);
    `CHK("freeze", 32'hffff_fffd, rd)
    for (int i = 0; i < 6; i++)
    begin
      n = (i < 2) ? i * 2 : 3 + ($unsigned($random(seed)) % 29);
      w = $random(seed);
      v = $random(seed);
      cs(1, CSR_MCNT_BASE + 12'(n), w, PRIV_M);
      cs(1, CSR_MCNT_BASE + 12'(n) + 12'h80, v, PRIV_M);
      cs(1, CSR_MGATE, $random(seed), PRIV_M);
      cs(0, CSR_MCNT_BASE + 12'(n), 0, PRIV_M);
      `CHK("cntLo", w, rd)
      cs(0, CSR_UCNT_BASE + 12'(n) + 12'h80, 0, PRIV_M);
      `CHK("shadowHi", v, rd)
    end
    k = 1 + ($unsigned($random(seed)) % 16);
    cs(1, CSR_SEL_BASE + 12'h3, k, PRIV_M);
    cs(1, CSR_SEL_BASE + 12'h4, 17, PRIV_M);
    cs(0, CSR_SEL_BASE + 12'h4, 0, PRIV_M);
    `CHK("selWarl", 32'h0, rd)
    for (int i = 2; i < 5; i++)
      cs(1, CSR_MCNT_BASE + 12'(i), 0, PRIV_M);
    cs(1, CSR_SEL_BASE, 32'hffff_ffe2, PRIV_M);
    w = $random(seed);
    cs(1, CSR_MCNT_BASE, w, PRIV_M);
    cs(0, CSR_MCNT_BASE, 0, PRIV_M);
    `CHK("cycle", w + 32'h1, rd)
    repeat (10)
    begin
      @(posedge ref_clk);
      instRetire <= 1'b1;
      eventBus <= 16'($random(seed)) | (16'h1 << (k - 1));
    end
    @(posedge ref_clk);
    instRetire <= 1'b0;
    eventBus <= '0;
    cs(1, CSR_SEL_BASE, 32'hffff_ffff, PRIV_M);
    for (int i = 2; i < 5; i++)
    begin
      cs(0, CSR_MCNT_BASE + 12'(i), 0, PRIV_M);
      `CHK("evtCount", (i < 4) ? 32'd10 : 32'd0, rd)
    end
    for (int i = 0; i < 8; i++)
    begin
      cs(1, CSR_MGATE, {31'h0, i[0]}, PRIV_M);
      cs(1, CSR_SGATE, {31'h0, i[1]}, PRIV_M);
      cs(0, CSR_UCNT_BASE, 0, i[2] ? PRIV_S : PRIV_U);
      `CHK("gate", expIll(i[2] ? PRIV_S : PRIV_U, i[0], i[1]), ill)
    end
    cs(1, CSR_UCNT_BASE, 0, PRIV_M);
    `CHK("shadowWr", 1'b1, ill)
    cs(0, CSR_MCNT_BASE + 12'h1, 0, PRIV_M);
    `CHK("mcntOne", 1'b1, ill)
    // machine counters stay closed to supervisor mode whatever the gates
    cs(0, CSR_MCNT_BASE, 0, PRIV_S);
    `CHK("mcntLower", 1'b1, ill)
    mm(1, MMIO_TIME_LO, 32'h10);
    mm(1, MMIO_TIME_HI, 0);
    // all ones to the low half, then the high half, then the new low
    mm(1, MMIO_CMP_LO, 32'hffff_ffff);
    mm(1, MMIO_CMP_HI, 0);
    mm(0, MMIO_CMP_LO, 0);
    `CHK("cmpHalf", 32'hffff_ffff, rd)
    mm(1, MMIO_CMP_LO, 32'h20);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK("pendLow", 1'b0, timerPending)
    base = steps;
    tbRun <= 1'b1;
    // look just after each edge, once pending and steps have settled
    for (int j = 0; j < 400 && timerPending !== 1'b1; j++)
    begin
      @(posedge ref_clk);
      #1;
    end
    tbRun <= 1'b0;
    `CHK("pendAt", 1'b1, steps - base inside {16, 17})
    repeat (8) @(posedge ref_clk);
    mm(0, MMIO_TIME_LO, 0);
    `CHK("wallStep", 32'(32'h10 + steps - base), rd)
    w = rd;
    cs(0, CSR_UCNT_BASE + 12'h1, 0, PRIV_M);
    `CHK("timeShadow", w, rd)
    mm(1, MMIO_CMP_LO, 32'hffff_ffff);
    @(posedge ref_clk);
    #1;
    `CHK("pendClr", 1'b0, timerPending)
    cs(1, CSR_IEN, 32'hffff_ffff, PRIV_M);
    cs(0, CSR_IEN, 0, PRIV_M);
    `CHK("ienWarl", 32'h80, rd)
    @(posedge ref_clk);
    globalIrqEnable <= 1'b1;
    mm(1, MMIO_CMP_LO, 0);
    @(posedge ref_clk);
    #1;
    `CHK("pendSet", 1'b1, timerPending)
    `CHK("take", 1'b1, timerIrqTake)
    cs(0, CSR_IPEND, 0, PRIV_M);
    `CHK("pendBit", 1'b1, rd[7])
    @(posedge ref_clk);
    globalIrqEnable <= 1'b0;
    #1;
    `CHK("takeOff", 1'b0, timerIrqTake)
    end_of_test;
  end
endmodule : test_machine_timer_and_perf_counters
`default_nettype wire
